// [inc/usp_pkg.sv]
// Purpose: constants and types for the three-mode serial port
// Assumes: byte-wide CPU register port, one system clock
// Notes: the design uses offsets and bit positions by name; the bench uses raw values
package usp_pkg;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'hFB;
  localparam logic [7:0] ADDR_DIV_LOW = 8'hFC;
  localparam logic [7:0] ADDR_CONTROL = 8'hFD;
  localparam logic [7:0] ADDR_PENDING = 8'hFE;
  localparam logic [7:0] ADDR_DATA = 8'hFF;

  localparam int CTL_TX_IE = 0;
  localparam int CTL_RX_IE = 1;
  localparam int CTL_RX_NINTH = 2;
  localparam int CTL_TX_NINTH = 3;
  localparam int CTL_RX_EN = 4;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MODE_HI = 7;
  localparam int PND_TX = 0;
  localparam int PND_RX = 1;
  localparam int PND_PERR = 2;
  localparam int PND_OVERRUN = 3;
  localparam int PND_PARITY_EN = 5;
  // Parity error is hardware owned; other bits software writable
  localparam logic [7:0] PND_WRITE_MASK = 8'hFB;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PENDING_RESET = 8'h00;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;

  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_ASYNC9 = 2'h2;

  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam logic [3:0] PHASE_MID = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int TX_FIFO_DEPTH = 32;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP, SH_TX, SH_RX}
    usp_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} usp_rx_state_t;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } usp_cpu_req_t;
endpackage

// [verilog/usp_serial_port.sv]
// Purpose: three-mode serial port with transmit FIFO
// Assumes: CPU register port synchronous to mclk
// Notes: mode 0 drives the receive pin while transmitting
`timescale 1ns/1ns
module usp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] count;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
  } usp_fifo_state_t;
  usp_fifo_state_t s_reg, s_next;
  logic push, pop;

  assign inReady = s_reg.count != (AW + 1)'(DEPTH);
  assign outValid = s_reg.count != '0;
  assign outData = s_reg.mem[s_reg.rdPtr];

  always_comb begin
    s_next = s_reg;
    push = inValid && inReady;
    pop = outValid && outReady;
    if (push) begin
      s_next.mem[s_reg.wrPtr] = inData;
      s_next.wrPtr = s_reg.wrPtr + 1'b1;
    end
    if (pop) begin
      s_next.rdPtr = s_reg.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

module usp_serial_port #(
  parameter int FIFO_DEPTH = usp_pkg::TX_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire usp_pkg::usp_cpu_req_t cpuReq,
  output logic [7:0] rdData,
  output logic txFifoReady,
  output logic irq,
  output logic txdOut,
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe_n
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] pending;
    logic [15:0] divider;
    logic [7:0] rxBuffer;
    logic [7:0] rdData;
    logic [15:0] baudCnt;
    usp_pkg::usp_tx_state_t txState;
    logic [3:0] txPhase;
    logic [2:0] txBit;
    logic [7:0] txShift;
    logic txNinth;
    logic txd;
    logic rxdOut;
    logic rxdDrive;
    usp_pkg::usp_rx_state_t rxState;
    logic [3:0] rxPhase;
    logic [2:0] rxBit;
    logic [7:0] rxShift;
    logic rxNinth;
  } usp_state_t;

  usp_state_t s_reg, s_next;
  logic tick, fifoPush, fifoPop, fifoValid;
  logic [7:0] fifoData;
  logic [1:0] mode;
  logic shiftMode, nineBit, parityOn;

  // Even sense gives a ninth bit that makes the one count even
  function automatic logic ninthParity(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  assign mode = s_reg.control[usp_pkg::CTL_MODE_HI:usp_pkg::CTL_MODE_LO];
  assign shiftMode = mode == usp_pkg::MODE_SHIFT;
  assign nineBit = mode == usp_pkg::MODE_ASYNC9;
  assign parityOn = nineBit && s_reg.pending[usp_pkg::PND_PARITY_EN];
  // Not equality: a lowered divider must not stall the count to wrap
  assign tick = s_reg.baudCnt >= s_reg.divider;
  assign fifoPush = cpuReq.wrEn && cpuReq.addr == usp_pkg::ADDR_DATA;

  usp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
    .mclk(mclk),
    .rst(rst),
    .inValid(fifoPush),
    .inReady(txFifoReady),
    .inData(cpuReq.wrData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  assign rdData = s_reg.rdData;
  assign txdOut = s_reg.txd;
  assign rxdOut = s_reg.rxdOut;
  assign rxdOe_n = ~s_reg.rxdDrive;
  assign irq = (s_reg.pending[usp_pkg::PND_RX] && s_reg.control[usp_pkg::CTL_RX_IE])
    || (s_reg.pending[usp_pkg::PND_TX] && s_reg.control[usp_pkg::CTL_TX_IE]);

  always_comb begin
    s_next = s_reg;
    fifoPop = 1'b0;
    // Divider gives the sixteen-times enable for every mode
    s_next.baudCnt = tick ? '0 : s_reg.baudCnt + 16'h0001;

    // CPU writes first so hardware sets below win over a clear
    if (cpuReq.wrEn) begin
      unique case (cpuReq.addr)
        usp_pkg::ADDR_CONTROL: s_next.control = cpuReq.wrData;
        usp_pkg::ADDR_PENDING: begin
          s_next.pending = (cpuReq.wrData & usp_pkg::PND_WRITE_MASK)
            | (s_reg.pending & ~usp_pkg::PND_WRITE_MASK);
        end
        usp_pkg::ADDR_DIV_HIGH: s_next.divider[15:8] = cpuReq.wrData;
        usp_pkg::ADDR_DIV_LOW: s_next.divider[7:0] = cpuReq.wrData;
        default: ;
      endcase
    end
    if (cpuReq.rdEn) begin
      unique case (cpuReq.addr)
        usp_pkg::ADDR_CONTROL: s_next.rdData = s_reg.control;
        usp_pkg::ADDR_PENDING: s_next.rdData = s_reg.pending;
        usp_pkg::ADDR_DIV_HIGH: s_next.rdData = s_reg.divider[15:8];
        usp_pkg::ADDR_DIV_LOW: s_next.rdData = s_reg.divider[7:0];
        usp_pkg::ADDR_DATA: s_next.rdData = s_reg.rxBuffer;
        default: s_next.rdData = 8'h00;
      endcase
    end

    // Transmitter, and the mode 0 shift engine in both directions
    unique case (s_reg.txState)
      usp_pkg::TX_IDLE: begin
        s_next.rxdDrive = 1'b0;
        s_next.txd = 1'b1;
        s_next.txPhase = '0;
        s_next.txBit = '0;
        if (fifoValid) begin
          fifoPop = 1'b1;
          s_next.txShift = fifoData;
          s_next.txNinth = parityOn
            ? ninthParity(fifoData, s_reg.control[usp_pkg::CTL_TX_NINTH])
            : s_reg.control[usp_pkg::CTL_TX_NINTH];
          s_next.txd = 1'b0;
          if (shiftMode) begin
            s_next.txState = usp_pkg::SH_TX;
            s_next.rxdDrive = 1'b1;
            s_next.rxdOut = fifoData[0];
          end else begin
            s_next.txState = usp_pkg::TX_START;
          end
        end else if (shiftMode && s_reg.control[usp_pkg::CTL_RX_EN]
                     && !s_reg.pending[usp_pkg::PND_RX]) begin
          s_next.txState = usp_pkg::SH_RX;
          s_next.txd = 1'b0;
        end
      end
      usp_pkg::TX_START: begin
        if (tick) begin
          s_next.txPhase = s_reg.txPhase + 4'h1;
          if (s_reg.txPhase == usp_pkg::PHASE_LAST) begin
            s_next.txState = usp_pkg::TX_DATA;
            s_next.txd = s_reg.txShift[0];
          end
        end
      end
      usp_pkg::TX_DATA: begin
        if (tick) begin
          s_next.txPhase = s_reg.txPhase + 4'h1;
          if (s_reg.txPhase == usp_pkg::PHASE_LAST) begin
            s_next.txShift = s_reg.txShift >> 1;
            s_next.txBit = s_reg.txBit + 3'h1;
            s_next.txd = s_reg.txShift[1];
            if (s_reg.txBit == usp_pkg::BIT_LAST) begin
              if (nineBit) begin
                s_next.txState = usp_pkg::TX_NINTH;
                s_next.txd = s_reg.txNinth;
              end else begin
                s_next.txState = usp_pkg::TX_STOP;
                s_next.txd = 1'b1;
                s_next.pending[usp_pkg::PND_TX] = 1'b1;
              end
            end
          end
        end
      end
      usp_pkg::TX_NINTH: begin
        if (tick) begin
          s_next.txPhase = s_reg.txPhase + 4'h1;
          if (s_reg.txPhase == usp_pkg::PHASE_LAST) begin
            s_next.txState = usp_pkg::TX_STOP;
            s_next.txd = 1'b1;
            s_next.pending[usp_pkg::PND_TX] = 1'b1;
          end
        end
      end
      usp_pkg::TX_STOP: begin
        if (tick) begin
          s_next.txPhase = s_reg.txPhase + 4'h1;
          if (s_reg.txPhase == usp_pkg::PHASE_LAST) begin
            s_next.txState = usp_pkg::TX_IDLE;
          end
        end
      end
      usp_pkg::SH_TX: begin
        if (tick) begin
          s_next.txPhase = s_reg.txPhase + 4'h1;
          // Shift clock low for the first half bit, high for the second
          s_next.txd = s_next.txPhase[3];
          if (s_reg.txPhase == usp_pkg::PHASE_LAST) begin
            s_next.txShift = s_reg.txShift >> 1;
            s_next.rxdOut = s_reg.txShift[1];
            s_next.txBit = s_reg.txBit + 3'h1;
            if (s_reg.txBit == usp_pkg::BIT_LAST) begin
              s_next.txState = usp_pkg::TX_IDLE;
              s_next.rxdDrive = 1'b0;
              s_next.txd = 1'b1;
              s_next.pending[usp_pkg::PND_TX] = 1'b1;
            end
          end
        end
      end
      usp_pkg::SH_RX: begin
        if (tick) begin
          s_next.txPhase = s_reg.txPhase + 4'h1;
          s_next.txd = s_next.txPhase[3];
          // Sample at the rising shift clock edge
          if (s_reg.txPhase == usp_pkg::PHASE_MID) begin
            s_next.rxShift = {rxdIn, s_reg.rxShift[7:1]};
          end
          if (s_reg.txPhase == usp_pkg::PHASE_LAST) begin
            s_next.txBit = s_reg.txBit + 3'h1;
            if (s_reg.txBit == usp_pkg::BIT_LAST) begin
              s_next.txState = usp_pkg::TX_IDLE;
              s_next.txd = 1'b1;
              s_next.rxBuffer = s_reg.rxShift;
              s_next.pending[usp_pkg::PND_RX] = 1'b1;
              s_next.pending[usp_pkg::PND_PERR] = 1'b0;
            end
          end
        end
      end
      default: s_next.txState = usp_pkg::TX_IDLE;
    endcase

    // Asynchronous receiver; idle while mode 0 is selected
    unique case (s_reg.rxState)
      usp_pkg::RX_IDLE: begin
        s_next.rxPhase = '0;
        s_next.rxBit = '0;
        if (!shiftMode && s_reg.control[usp_pkg::CTL_RX_EN] && !rxdIn) begin
          s_next.rxState = usp_pkg::RX_START;
        end
      end
      usp_pkg::RX_START: begin
        if (tick) begin
          s_next.rxPhase = s_reg.rxPhase + 4'h1;
          // A start bit gone high by mid bit was a glitch
          if (s_reg.rxPhase == usp_pkg::PHASE_MID && rxdIn) begin
            s_next.rxState = usp_pkg::RX_IDLE;
          end else if (s_reg.rxPhase == usp_pkg::PHASE_LAST) begin
            s_next.rxState = usp_pkg::RX_DATA;
          end
        end
      end
      usp_pkg::RX_DATA: begin
        if (tick) begin
          s_next.rxPhase = s_reg.rxPhase + 4'h1;
          if (s_reg.rxPhase == usp_pkg::PHASE_MID) begin
            s_next.rxShift = {rxdIn, s_reg.rxShift[7:1]};
          end
          if (s_reg.rxPhase == usp_pkg::PHASE_LAST) begin
            s_next.rxBit = s_reg.rxBit + 3'h1;
            if (s_reg.rxBit == usp_pkg::BIT_LAST) begin
              s_next.rxState = nineBit ? usp_pkg::RX_NINTH : usp_pkg::RX_STOP;
              if (!parityOn) begin
                s_next.pending[usp_pkg::PND_PERR] = 1'b0;
              end
            end
          end
        end
      end
      usp_pkg::RX_NINTH: begin
        if (tick) begin
          s_next.rxPhase = s_reg.rxPhase + 4'h1;
          if (s_reg.rxPhase == usp_pkg::PHASE_MID) begin
            s_next.rxNinth = rxdIn;
            if (parityOn) begin
              s_next.pending[usp_pkg::PND_PERR] = rxdIn
                != ninthParity(s_reg.rxShift, s_reg.control[usp_pkg::CTL_RX_NINTH]);
            end
          end
          if (s_reg.rxPhase == usp_pkg::PHASE_LAST) begin
            s_next.rxState = usp_pkg::RX_STOP;
          end
        end
      end
      usp_pkg::RX_STOP: begin
        if (tick) begin
          s_next.rxPhase = s_reg.rxPhase + 4'h1;
          if (s_reg.rxPhase == usp_pkg::PHASE_MID) begin
            // Finish at mid stop so the next start edge is not missed
            s_next.rxState = usp_pkg::RX_IDLE;
            s_next.rxBuffer = s_reg.rxShift;
            s_next.pending[usp_pkg::PND_OVERRUN] = s_reg.pending[usp_pkg::PND_RX]
              || s_next.pending[usp_pkg::PND_OVERRUN];
            s_next.pending[usp_pkg::PND_RX] = 1'b1;
            if (mode == usp_pkg::MODE_ASYNC8) begin
              s_next.control[usp_pkg::CTL_RX_NINTH] = rxdIn;
            end else if (!parityOn) begin
              s_next.control[usp_pkg::CTL_RX_NINTH] = s_reg.rxNinth;
            end
          end
        end
      end
      default: s_next.rxState = usp_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.control <= usp_pkg::CONTROL_RESET;
      s_reg.pending <= usp_pkg::PENDING_RESET;
      s_reg.divider <= usp_pkg::DIVIDER_RESET;
      s_reg.txd <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  chk_control_reset: assert property (@(posedge mclk)
    $fell(rst) |-> s_reg.control == usp_pkg::CONTROL_RESET)
    else $error("control not cleared by reset");

  chk_tx_stop_flag: assert property (@(posedge mclk) disable iff (rst)
    (s_reg.txState == usp_pkg::TX_STOP && $past(s_reg.txState) != usp_pkg::TX_STOP)
    |-> s_reg.pending[usp_pkg::PND_TX] && s_reg.txd)
    else $error("transmit pending not set at stop bit start");

  chk_start_bit_low: assert property (@(posedge mclk) disable iff (rst)
    s_reg.txState == usp_pkg::TX_START |-> !txdOut && rxdOe_n)
    else $error("start bit not low");

  chk_shift_clock: assert property (@(posedge mclk) disable iff (rst)
    (s_reg.txState == usp_pkg::SH_TX) |-> txdOut == s_reg.txPhase[3] && !rxdOe_n)
    else $error("mode 0 shift clock or data drive wrong");

  chk_mode0_rx_done: assert property (@(posedge mclk) disable iff (rst)
    ($past(s_reg.txState) == usp_pkg::SH_RX && s_reg.txState == usp_pkg::TX_IDLE)
    |-> s_reg.pending[usp_pkg::PND_RX] && s_reg.rxBuffer == $past(s_reg.rxShift))
    else $error("mode 0 receive did not complete");

  chk_mode0_rx_start: assert property (@(posedge mclk) disable iff (rst)
    ($past(s_reg.txState) == usp_pkg::TX_IDLE && s_reg.txState == usp_pkg::SH_RX)
    |-> !$past(s_reg.pending[usp_pkg::PND_RX]) && $past(s_reg.control[usp_pkg::CTL_RX_EN]))
    else $error("mode 0 receive started without its conditions");

  chk_async_rx_start: assert property (@(posedge mclk) disable iff (rst)
    ($past(s_reg.rxState) == usp_pkg::RX_IDLE && s_reg.rxState == usp_pkg::RX_START)
    |-> !$past(rxdIn) && $past(s_reg.control[usp_pkg::CTL_RX_EN]))
    else $error("receive started without a low start bit");

  chk_parity_mode: assert property (@(posedge mclk) disable iff (rst)
    $rose(s_reg.pending[usp_pkg::PND_PERR]) |-> $past(parityOn))
    else $error("parity error outside mode 2 parity");

  chk_irq_gate: assert property (@(posedge mclk) disable iff (rst)
    (s_reg.pending[usp_pkg::PND_TX] && !s_reg.control[usp_pkg::CTL_TX_IE]
     && !s_reg.pending[usp_pkg::PND_RX]) |-> !irq)
    else $error("interrupt raised while masked");

  chk_async_rx_done: assert property (@(posedge mclk) disable iff (rst)
    ($past(s_reg.rxState) == usp_pkg::RX_STOP && s_reg.rxState == usp_pkg::RX_IDLE)
    |-> s_reg.pending[usp_pkg::PND_RX] && $past(s_reg.rxPhase) == usp_pkg::PHASE_MID)
    else $error("receive pending not set at stop middle");
endmodule

// [testbench/usp_remote_model.sv]
// Purpose: remote serial device on the port's two pins
// Assumes: bitClks mclk periods per bit, set by the bench
// Notes: idle receive line held high as by a pull-up
`timescale 1ns/1ns
module usp_remote_model (
  input wire logic mclk,
  input wire logic txdOut,
  input wire logic rxdOut,
  input wire logic rxdOe_n,
  input wire logic [1:0] mode,
  output logic rxdIn
);
  int bitClks = 16;
  int m0i = 0;
  int m0n = 0;
  logic [7:0] m0Byte = 8'h00;
  logic [7:0] m0Got = 8'h00;
  logic [9:0] rxQ[$];
  initial rxdIn = 1'b1;
  // Frame bit 0 goes first: start, data LSB first, ninth, stop
  task automatic send(input logic [10:0] frame, input int n);
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      rxdIn <= frame[i];
      repeat (bitClks) @(posedge mclk);
    end
    rxdIn <= 1'b1;
  endtask
  // Async capture, each bit taken at its centre
  always begin
    logic [9:0] f;
    @(negedge txdOut);
    f = 10'h3FF;
    if (mode != 2'h0) begin
      repeat (bitClks / 2) @(posedge mclk);
      for (int i = 0; i < ((mode == 2'h2) ? 10 : 9); i++) begin
        repeat (bitClks) @(posedge mclk);
        f[i] = txdOut;
      end
      rxQ.push_back(f);
    end
  end
  always @(posedge txdOut) begin
    if (mode == 2'h0 && !rxdOe_n) begin
      m0Got = {rxdOut, m0Got[7:1]};
      m0n++;
      if (m0n == 8) begin
        rxQ.push_back({2'b00, m0Got});
        m0n = 0;
      end
    end
  end
  // Next bit shown after the shift clock falls, well before it rises
  always @(negedge txdOut) begin
    #1;
    if (mode == 2'h0 && rxdOe_n) begin
      rxdIn <= m0Byte[m0i];
      m0i = (m0i + 1) % 8;
    end
  end
endmodule

// [testbench/testbench.sv]
// Purpose: self-checking bench for the three-mode serial port
// Assumes: FIFO shortened to 4 words to keep fill time short
// Notes: bench resolves the shared receive pin from the enables
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  usp_pkg::usp_cpu_req_t cpuReq = '0;
  logic [7:0] rdData;
  logic txFifoReady, irq, txdOut, rxdOut, rxdOe_n, farRxd, rxdWire;
  logic [1:0] mode = 2'h1;
  logic [31:0] seed = 32'h00016FC9;
  int n_fail = 0;
  int tests_run = 0;
  assign rxdWire = rxdOe_n ? farRxd : rxdOut;
  usp_serial_port #(.FIFO_DEPTH(4)) dut (.mclk(mclk), .rst(rst), .cpuReq(cpuReq),
    .rdData(rdData), .txFifoReady(txFifoReady), .irq(irq), .txdOut(txdOut),
    .rxdIn(rxdWire), .rxdOut(rxdOut), .rxdOe_n(rxdOe_n));
  usp_remote_model far (.mclk(mclk), .txdOut(txdOut), .rxdOut(rxdOut),
    .rxdOe_n(rxdOe_n), .mode(mode), .rxdIn(farRxd));
  initial forever #10 mclk = ~mclk;
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [10:0] frm(input logic [7:0] d, input logic n9);
    return {1'b1, n9, d, 1'b0};
  endfunction
  task automatic test_done;
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    cpuReq <= {1'b1, 1'b0, a, v};
    @(posedge mclk);
    cpuReq <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    cpuReq <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    cpuReq <= '0;
    #1;
    v = rdData;
  endtask
  task automatic waitFe(input int b);
    logic [7:0] v;
    int k;
    v = 8'h00;
    for (k = 0; k < 3000 && v[b] !== 1'b1; k++) rd(8'hFE, v);
    chk({9'h0, v[b]}, 10'h001, "pending flag not set");
  endtask
  task automatic popQ(output logic [9:0] f);
    int k;
    for (k = 0; k < 3000 && far.rxQ.size() == 0; k++) @(posedge mclk);
    f = (far.rxQ.size() > 0) ? far.rxQ.pop_front() : 10'h3FF;
  endtask
  initial begin
    #2000000;
    n_fail++;
    test_done();
  end
  initial begin
    logic [7:0] d, v, dv;
    logic [9:0] f;
    logic bad, sns, parity_enable;
    logic [7:0] q[$];
    int k;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(8'hFD, v);
    chk(v, 8'h00, "control reset");
    rd(8'hFE, v);
    chk(v, 8'h00, "pending reset");
    rd(8'h10, v);
    chk(v, 8'h00, "unmapped read");
    wr(8'hFE, 8'hFF);
    rd(8'hFE, v);
    chk(v, 8'hFB, "pending write mask");
    chk(irq, 1'b0, "irq without enable");
    wr(8'hFD, 8'h01);
    chk(irq, 1'b1, "tx irq enable");
    wr(8'hFD, 8'h02);
    chk(irq, 1'b1, "rx irq enable");
    wr(8'hFE, 8'h00);
    chk(irq, 1'b0, "irq after clear");
    wr(8'hFB, 8'h00);
    // Mode 1 transmit at random divider, timing seen on irq
    for (int i = 0; i < 4; i++) begin
      dv = rnd() % 3;
      far.bitClks = 16 * (dv + 1);
      wr(8'hFC, dv);
      rd(8'hFC, v);
      chk(v, dv, "divider readback");
      wr(8'hFD, 8'h41);
      d = rnd();
      wr(8'hFF, d);
      // Look just after each edge; tick phase may shorten the frame by a clock or two
      for (k = 0; k < 5000 && irq !== 1'b1; k++) begin
        @(posedge mclk);
        #1;
      end
      chk(10'(k + 2 >= 9 * far.bitClks && k <= 9 * far.bitClks + 2), 10'h1, "stop start");
      popQ(f);
      chk(f[8:0], {1'b1, d}, "mode 1 frame");
      // Let the stop bit finish before the next frame is timed
      repeat (far.bitClks) @(posedge mclk);
      wr(8'hFE, 8'h00);
    end
    // Mode 1 receive, parity enable has no effect, then overrun
    wr(8'hFE, 8'h20);
    wr(8'hFD, 8'h52);
    d = rnd();
    far.send(frm(d, 1'b1), 10);
    waitFe(1);
    chk(irq, 1'b1, "rx irq");
    rd(8'hFF, v);
    chk(v, d, "mode 1 receive");
    rd(8'hFD, v);
    chk(v[2], 1'b1, "stop bit stored");
    rd(8'hFE, v);
    chk(v[2], 1'b0, "no parity in mode 1");
    far.send(frm(rnd(), 1'b1), 10);
    d = rnd();
    far.send(frm(d, 1'b1), 10);
    waitFe(3);
    rd(8'hFF, v);
    chk(v, d, "overrun keeps newest");
    // Mode 2 with every parity setting, both directions
    mode = 2'h2;
    for (int c = 0; c < 4; c++) begin
      parity_enable = c[1];
      sns = c[0];
      bad = rnd() % 2;
      wr(8'hFE, {2'b00, parity_enable, 5'h00});
      wr(8'hFD, {4'h9, sns, sns, 2'b00});
      d = rnd();
      wr(8'hFF, d);
      popQ(f);
      chk(f, {1'b1, parity_enable ? ((^d) ^ sns) : sns, d}, "mode 2 frame");
      d = rnd();
      far.send(frm(d, parity_enable ? ((^d) ^ sns ^ bad) : bad), 11);
      waitFe(1);
      rd(8'hFE, v);
      chk(v[2], parity_enable & bad, "parity error flag");
      rd(8'hFF, v);
      chk(v, d, "mode 2 receive");
      rd(8'hFD, v);
      if (!parity_enable) chk(v[2], bad, "received ninth bit");
    end
    // Mode 0 transmit then receive
    mode = 2'h0;
    wr(8'hFD, 8'h00);
    wr(8'hFE, 8'h00);
    d = rnd();
    wr(8'hFF, d);
    popQ(f);
    chk(f[7:0], d, "mode 0 transmit");
    waitFe(0);
    far.m0Byte = rnd();
    far.m0i = 0;
    wr(8'hFE, 8'h00);
    wr(8'hFD, 8'h10);
    waitFe(1);
    rd(8'hFF, v);
    chk(v, far.m0Byte, "mode 0 receive");
    // Fill the transmit FIFO until it refuses, then drain
    mode = 2'h1;
    far.bitClks = 48;
    wr(8'hFC, 8'h02);
    wr(8'hFD, 8'h40);
    for (k = 0; k < 40 && txFifoReady === 1'b1; k++) begin
      d = rnd();
      q.push_back(d);
      wr(8'hFF, d);
    end
    chk(txFifoReady, 1'b0, "fifo full");
    wr(8'hFF, 8'hA5);
    foreach (q[i]) begin
      popQ(f);
      chk(f[7:0], q[i], "fifo order");
    end
    repeat (600) @(posedge mclk);
    chk(10'(far.rxQ.size()), 10'h0, "dropped write sent");
    chk(txFifoReady, 1'b1, "fifo drained");
    test_done();
  end
endmodule
